// file: utr_defines.svh
// Constants of the serial port data path: codes, field widths, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef UTR_DEFINES_SVH
`define UTR_DEFINES_SVH

`define UTR_CHAR9        3'h7
`define UTR_DATA_W       9
`define UTR_RATE_W       12
`define UTR_OS_NORMAL    4'hF
`define UTR_OS_DOUBLE    4'h7
`define UTR_HALF_NORMAL  4'h7
`define UTR_HALF_DOUBLE  4'h3
`define UTR_RXBUF_DEPTH  2
`define UTR_RESET_RATE   12'h000
`define UTR_LINE_IDLE    1'b1
`define UTR_LINE_START   1'b0

`endif

// file: utr_pkg.sv
// Types shared by the serial port data path modules.
// Assumes utr_defines.svh is on the include path.
`include "utr_defines.svh"

package utr_pkg;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_PAR   = 3'b011,
      TX_STOP  = 3'b100
   } utr_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100,
      RX_HOLD  = 3'b101
   } utr_rx_state_t;

endpackage : utr_pkg

// file: utr_rx_fifo.sv
// Two-entry receive buffer with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "utr_defines.svh"

module utr_rx_fifo #(
   parameter int W     = `UTR_DATA_W,
   parameter int DEPTH = `UTR_RXBUF_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   // Full at DEPTH words; the count is one bit wider than the pointers
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : nxt

   always_comb begin
      wp_d  = push ? nxt(wp_q) : wp_q;
      rp_d  = pop ? nxt(rp_q) : rp_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; a word is only read once counted in
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

endmodule : utr_rx_fifo

// file: utr_datapath.sv
// Transmit and receive data path of a serial port with plain control ports.
// Assumes CLK at 25 MHz, software-side strobes on CLK, TXD/RXD/EXTERNAL_CLOCK_PIN as pins.
`timescale 1ns/1ps
`include "utr_defines.svh"

module utr_datapath (
   input  wire logic                     CLK,
   input  wire logic                     NRST,
   input  wire logic                     TX_ENABLE,
   input  wire logic                     RX_ENABLE,
   input  wire logic                     SYNC_MODE,
   input  wire logic                     DOUBLE_SPEED,
   input  wire logic [2:0]               CHAR_SIZE,
   input  wire logic                     PARITY_EN,
   input  wire logic                     PARITY_ODD,
   input  wire logic                     STOP_TWO,
   input  wire logic [`UTR_RATE_W-1:0]   RATE_DIV,
   input  wire logic                     RATE_LOAD,
   input  wire logic                     NINTH_TX_BIT,
   input  wire logic                     DATA_WR,
   input  wire logic [7:0]               DATA_WDATA,
   input  wire logic                     TXC_CLEAR,
   input  wire logic                     TXC_IRQ_ACK,
   input  wire logic                     BUF_EMPTY_IRQ_EN,
   input  wire logic                     TXC_IRQ_EN,
   output logic                          BUF_EMPTY_FLAG,
   output logic                          TXC_FLAG,
   output logic                          BUF_EMPTY_IRQ,
   output logic                          TXC_IRQ,
   output logic                          TXD_O,
   output logic                          TXD_OE,
   input  wire logic                     RXD_I,
   output logic                          RXD_TAKEN,
   input  wire logic                     XCK_I,
   output logic                          XCK_TAKEN,
   output logic                          RX_VALID,
   input  wire logic                     RX_READY,
   output logic [`UTR_DATA_W-1:0]        RX_DATA
);

   ////////////////////////////////////////////////////////////////////////////
   // Character size decoding; nbits serves both directions, char_mask only the transmitter

   function automatic logic [3:0] char_bits(input logic [2:0] code);
      char_bits = (code == `UTR_CHAR9) ? 4'h9 : {2'b01, code[1:0]} + 4'h1;
   endfunction : char_bits

   function automatic logic [`UTR_DATA_W-1:0] char_mask(input logic [2:0] code);
      char_mask = (code == `UTR_CHAR9) ? 9'h1FF : 9'h0FF >> (2'h3 - code[1:0]);
   endfunction : char_mask

   logic [3:0] nbits;
   assign nbits = char_bits(CHAR_SIZE);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and clock edge detection

   logic rxd_s1_q, rxd_s2_q, xck_s1_q, xck_s2_q, xck_s3_q;
   logic xck_rise, xck_fall;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rxd_s1_q <= `UTR_LINE_IDLE;
         rxd_s2_q <= `UTR_LINE_IDLE;
         xck_s1_q <= 1'b0;
         xck_s2_q <= 1'b0;
         xck_s3_q <= 1'b0;
      end else begin
         rxd_s1_q <= RXD_I;
         rxd_s2_q <= rxd_s1_q;
         xck_s1_q <= XCK_I;
         xck_s2_q <= xck_s1_q;
         xck_s3_q <= xck_s2_q;
      end
   end

   assign xck_rise = xck_s2_q & ~xck_s3_q;
   assign xck_fall = ~xck_s2_q & xck_s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // Rate generator and transmit prescaler

   logic [`UTR_RATE_W-1:0] rate_q, rate_d;
   logic [3:0]             txpre_q, txpre_d;
   logic                   rate_tick, tx_tick;
   logic [3:0]             os_top, os_half;

   assign rate_tick = (rate_q == '0);
   assign os_top    = DOUBLE_SPEED ? `UTR_OS_DOUBLE : `UTR_OS_NORMAL;
   assign os_half   = DOUBLE_SPEED ? `UTR_HALF_DOUBLE : `UTR_HALF_NORMAL;

   assign tx_tick = SYNC_MODE ? xck_rise : (rate_tick && txpre_q == os_top);

   always_comb begin
      rate_d  = (RATE_LOAD || rate_tick) ? RATE_DIV : rate_q - 1'b1;
      txpre_d = txpre_q;
      if (rate_tick) begin
         txpre_d = (txpre_q == os_top) ? 4'h0 : txpre_q + 4'h1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rate_q  <= `UTR_RESET_RATE;
         txpre_q <= 4'h0;
      end else begin
         rate_q  <= rate_d;
         txpre_q <= txpre_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter

   utr_pkg::utr_tx_state_t  txs_q, txs_d;
   logic [`UTR_DATA_W-1:0]  tbuf_q, tbuf_d, tsh_q, tsh_d;
   logic                    tfull_q, tfull_d, tpar_q, tpar_d;
   logic [3:0]              tcnt_q, tcnt_d;
   logic                    tstop2_q, tstop2_d, line_q, line_d;
   logic                    txc_q, txc_d, txon_q, txon_d;
   logic                    tload, tset_txc;

   always_comb begin
      txs_d    = txs_q;
      tbuf_d   = tbuf_q;
      tfull_d  = tfull_q;
      tsh_d    = tsh_q;
      tpar_d   = tpar_q;
      tcnt_d   = tcnt_q;
      tstop2_d = tstop2_q;
      line_d   = line_q;
      tload    = 1'b0;
      tset_txc = 1'b0;
      // stay on until shifter and buffer drain
      txon_d = TX_ENABLE | (txon_q & (txs_q != utr_pkg::TX_IDLE || tfull_q));
      if (tx_tick && txon_q) begin
         case (txs_q)
            utr_pkg::TX_IDLE: begin
               tload = tfull_q;
            end
            utr_pkg::TX_START: begin
               line_d = tsh_q[0];
               tsh_d  = tsh_q >> 1;
               tcnt_d = 4'h1;
               txs_d  = utr_pkg::TX_DATA;
            end
            utr_pkg::TX_DATA: begin
               if (tcnt_q == nbits) begin
                  line_d   = PARITY_EN ? tpar_q : `UTR_LINE_IDLE;
                  txs_d    = PARITY_EN ? utr_pkg::TX_PAR : utr_pkg::TX_STOP;
                  tstop2_d = 1'b0;
               end else begin
                  line_d = tsh_q[0];
                  tsh_d  = tsh_q >> 1;
                  tcnt_d = tcnt_q + 4'h1;
               end
            end
            utr_pkg::TX_PAR: begin
               line_d   = `UTR_LINE_IDLE;
               tstop2_d = 1'b0;
               txs_d    = utr_pkg::TX_STOP;
            end
            utr_pkg::TX_STOP: begin
               if (STOP_TWO && !tstop2_q) begin
                  tstop2_d = 1'b1;
               end else begin
                  tload = tfull_q;
                  tset_txc = ~tfull_q;
                  txs_d    = utr_pkg::TX_IDLE;
               end
            end
            default: begin
               txs_d  = utr_pkg::TX_IDLE;
               line_d = `UTR_LINE_IDLE;
            end
         endcase
      end
      if (tload) begin
         // unused high bits dropped by mask
         tsh_d   = tbuf_q & char_mask(CHAR_SIZE);
         tpar_d  = (^(tbuf_q & char_mask(CHAR_SIZE))) ^ PARITY_ODD;
         tfull_d = 1'b0;
         line_d  = `UTR_LINE_START;
         txs_d   = utr_pkg::TX_START;
      end
      // write fills buffer; ninth bit taken now
      if (DATA_WR) begin
         tbuf_d  = {NINTH_TX_BIT, DATA_WDATA};
         tfull_d = 1'b1;
      end
      // clear by service or write-one; set wins
      txc_d = tset_txc | (txc_q & ~(TXC_CLEAR | TXC_IRQ_ACK));
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         txs_q    <= utr_pkg::TX_IDLE;
         tbuf_q   <= '0;
         tfull_q  <= 1'b0;
         tsh_q    <= '0;
         tpar_q   <= 1'b0;
         tcnt_q   <= 4'h0;
         tstop2_q <= 1'b0;
         line_q   <= `UTR_LINE_IDLE;
         txc_q    <= 1'b0;
         txon_q   <= 1'b0;
      end else begin
         txs_q    <= txs_d;
         tbuf_q   <= tbuf_d;
         tfull_q  <= tfull_d;
         tsh_q    <= tsh_d;
         tpar_q   <= tpar_d;
         tcnt_q   <= tcnt_d;
         tstop2_q <= tstop2_d;
         line_q   <= line_d;
         txc_q    <= txc_d;
         txon_q   <= txon_d;
      end
   end

   // pin override while enabled or draining
   assign TXD_OE = txon_q;
   assign TXD_O  = line_q;
   assign BUF_EMPTY_FLAG = ~tfull_q;
   // level interrupt while flag and enable
   assign BUF_EMPTY_IRQ  = ~tfull_q & BUF_EMPTY_IRQ_EN;
   assign TXC_FLAG       = txc_q;
   assign TXC_IRQ        = txc_q & TXC_IRQ_EN;

   ////////////////////////////////////////////////////////////////////////////
   // Receiver

   utr_pkg::utr_rx_state_t  rxs_q, rxs_d;
   logic [`UTR_DATA_W-1:0]  rsh_q, rsh_d;
   logic [3:0]              rcnt_q, rcnt_d, ros_q, ros_d;
   logic                    rsample, push_ready;

   // sample on falling external edge when synchronous
   assign rsample = SYNC_MODE ? xck_fall : (rate_tick && ros_q == os_top);

   always_comb begin
      rxs_d  = rxs_q;
      rsh_d  = rsh_q;
      rcnt_d = rcnt_q;
      ros_d  = (rate_tick && rxs_q != utr_pkg::RX_IDLE) ? ros_q + 4'h1 : ros_q;
      if (rsample) begin
         ros_d = 4'h0;
      end
      case (rxs_q)
         utr_pkg::RX_IDLE: begin
            ros_d  = 4'h0;
            rcnt_d = 4'h0;
            rsh_d  = '0;
            if (SYNC_MODE ? (xck_fall && !rxd_s2_q) : (rate_tick && !rxd_s2_q)) begin
               rxs_d = SYNC_MODE ? utr_pkg::RX_DATA : utr_pkg::RX_START;
            end
         end
         utr_pkg::RX_START: begin
            // start must still be low mid-bit
            if (rate_tick && ros_q == os_half) begin
               ros_d = 4'h0;
               rxs_d = rxd_s2_q ? utr_pkg::RX_IDLE : utr_pkg::RX_DATA;
            end
         end
         utr_pkg::RX_DATA: begin
            if (rsample) begin
               rsh_d[rcnt_q] = rxd_s2_q;
               rcnt_d        = rcnt_q + 4'h1;
               if (rcnt_q + 4'h1 == nbits) begin
                  rxs_d = PARITY_EN ? utr_pkg::RX_PAR : utr_pkg::RX_STOP;
               end
            end
         end
         utr_pkg::RX_PAR: begin
            if (rsample) begin
               rxs_d = utr_pkg::RX_STOP;
            end
         end
         utr_pkg::RX_STOP: begin
            if (rsample) begin
               rxs_d = utr_pkg::RX_HOLD;
            end
         end
         utr_pkg::RX_HOLD: begin
            if (push_ready) begin
               rxs_d = utr_pkg::RX_IDLE;
            end
         end
         default: begin
            rxs_d = utr_pkg::RX_IDLE;
         end
      endcase
      // Disable is immediate; a partial frame is dropped
      if (!RX_ENABLE) begin
         rxs_d = utr_pkg::RX_IDLE;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rxs_q  <= utr_pkg::RX_IDLE;
         rsh_q  <= '0;
         rcnt_q <= 4'h0;
         ros_q  <= 4'h0;
      end else begin
         rxs_q  <= rxs_d;
         rsh_q  <= rsh_d;
         rcnt_q <= rcnt_d;
         ros_q  <= ros_d;
      end
   end

   // Full buffer stalls the receiver in HOLD; a later frame may be missed
   utr_rx_fifo #(
      .W     (`UTR_DATA_W),
      .DEPTH (`UTR_RXBUF_DEPTH)
   ) u_rx_fifo (
      .clk       (CLK),
      .nrst      (NRST),
      .in_valid  (rxs_q == utr_pkg::RX_HOLD),
      .in_ready  (push_ready),
      .in_data   (rsh_q),
      .out_valid (RX_VALID),
      .out_ready (RX_READY),
      .out_data  (RX_DATA)
   );

   assign RXD_TAKEN = RX_ENABLE;
   assign XCK_TAKEN = SYNC_MODE & (txon_q | RX_ENABLE);

endmodule : utr_datapath

// file: utr_datapath_monitor.sv
// Checker of the serial port data path, watching only top-level ports.
// Assumes synchronous slave clocking while the clear check is exercised.
`timescale 1ns/1ps
`include "utr_defines.svh"

module utr_datapath_monitor (
   input wire logic                   CLK,
   input wire logic                   NRST,
   input wire logic                   TX_ENABLE,
   input wire logic                   RX_ENABLE,
   input wire logic                   SYNC_MODE,
   input wire logic [2:0]             CHAR_SIZE,
   input wire logic                   DATA_WR,
   input wire logic                   TXC_CLEAR,
   input wire logic                   TXC_IRQ_ACK,
   input wire logic                   BUF_EMPTY_IRQ_EN,
   input wire logic                   TXC_IRQ_EN,
   input wire logic                   XCK_I,
   input wire logic                   RX_READY,
   input wire logic                   BUF_EMPTY_FLAG,
   input wire logic                   TXC_FLAG,
   input wire logic                   BUF_EMPTY_IRQ,
   input wire logic                   TXC_IRQ,
   input wire logic                   TXD_O,
   input wire logic                   TXD_OE,
   input wire logic                   RXD_TAKEN,
   input wire logic                   XCK_TAKEN,
   input wire logic                   RX_VALID,
   input wire logic [`UTR_DATA_W-1:0] RX_DATA
);
   logic [`UTR_DATA_W-1:0] rx_hi;

   // Bits above the character length
   assign rx_hi = RX_DATA >> (5 + CHAR_SIZE[1:0]);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // No tick can land while the link clock sits low
   sequence s_xck_quiet;
      (SYNC_MODE && !XCK_I)[*5];
   endsequence
   sequence s_move;
      $rose(BUF_EMPTY_FLAG) && TXD_OE;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////////////////
   AST_TX_ON: assert property (TX_ENABLE[*3] |-> TXD_OE)
      else $error("transmit pin not taken");
   AST_XCK_TAKE: assert property (SYNC_MODE && (RX_ENABLE || (TX_ENABLE && TXD_OE))
      |-> XCK_TAKEN) else $error("clock pin not taken");
   AST_WR_CLR: assert property (DATA_WR |=> !BUF_EMPTY_FLAG)
      else $error("write left buffer empty");
   AST_BE_IRQ: assert property (BUF_EMPTY_IRQ == (BUF_EMPTY_FLAG && BUF_EMPTY_IRQ_EN))
      else $error("empty interrupt mismatch");
   AST_START: assert property (s_move |-> !TXD_O)
      else $error("no start bit at buffer move");
   AST_TXC_SET: assert property ($rose(TXC_FLAG) |-> BUF_EMPTY_FLAG)
      else $error("complete set with word waiting");
   AST_TXC_CLR: assert property (s_xck_quiet ##0 (TXC_CLEAR || TXC_IRQ_ACK)
      |=> !TXC_FLAG) else $error("complete flag not cleared");
   AST_TXC_IRQ: assert property (TXC_IRQ == (TXC_FLAG && TXC_IRQ_EN))
      else $error("complete interrupt mismatch");
   AST_OE_HOLD: assert property (TXD_OE && !BUF_EMPTY_FLAG |=> TXD_OE)
      else $error("pin released with word waiting");
   AST_RXD_TAKE: assert property (RXD_TAKEN == RX_ENABLE)
      else $error("receive pin ownership wrong");
   AST_RX_HOLD: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
      else $error("receive word lost");
   AST_RX_MASK: assert property (RX_VALID && CHAR_SIZE != 3'h7 |-> rx_hi == 9'h000)
      else $error("unused receive bits not zero");
endmodule : utr_datapath_monitor

bind utr_datapath utr_datapath_monitor i_mon (
   .CLK(CLK), .NRST(NRST), .TX_ENABLE(TX_ENABLE), .RX_ENABLE(RX_ENABLE),
   .SYNC_MODE(SYNC_MODE), .CHAR_SIZE(CHAR_SIZE), .DATA_WR(DATA_WR), .TXC_CLEAR(TXC_CLEAR),
   .TXC_IRQ_ACK(TXC_IRQ_ACK), .BUF_EMPTY_IRQ_EN(BUF_EMPTY_IRQ_EN), .TXC_IRQ_EN(TXC_IRQ_EN),
   .XCK_I(XCK_I), .RX_READY(RX_READY), .BUF_EMPTY_FLAG(BUF_EMPTY_FLAG), .TXC_FLAG(TXC_FLAG),
   .BUF_EMPTY_IRQ(BUF_EMPTY_IRQ), .TXC_IRQ(TXC_IRQ), .TXD_O(TXD_O), .TXD_OE(TXD_OE),
   .RXD_TAKEN(RXD_TAKEN), .XCK_TAKEN(XCK_TAKEN), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA)
);

// file: utr_peer.sv
// Far-side serial peer: makes the link clock, drives the receive line, samples transmit.
// Assumes the bench resolves the transmit pin with a pull-up.
`timescale 1ns/1ps

module utr_peer (
   output logic      external_clock_pin,
   output logic      rxd,
   input  wire logic txd
);
   logic [31:0] cap;

   // Clock stands still and line idles high outside frames
   initial begin
      external_clock_pin = 1'b0;
      rxd = 1'b1;
      cap = 32'hFFFF_FFFF;
   end

   // Bit n-1 is sampled just before the next rising edge, late in its cell
   task automatic run(input int n, input logic [31:0] frm);
      cap = 32'hFFFF_FFFF;
      #7;
      for (int i = 0; i <= n; i++) begin
         if (i > 0)
            cap[i-1] = txd;
         external_clock_pin = 1'b1;
         rxd = frm[i];
         #160;
         external_clock_pin = 1'b0;
         #160;
      end
      rxd = 1'b1;
   endtask : run
endmodule : utr_peer

// file: tb_top.sv
// Self-checking bench of the serial port data path, mostly synchronous slave, one async send.
// Assumes the design, the peer model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "utr_defines.svh"

module tb_top;
   logic                   clk, nrst, tx_en, rx_en, wr_stb, ninth, clr, ack;
   logic                   be_ien, txc_ien, rdy, pe, po, st2;
   logic                   sync, dspd, rld;
   logic [`UTR_RATE_W-1:0] rdiv;
   logic [2:0]             csz;
   logic [7:0]             wdat;
   logic                   be_flag, txc_flag, be_irq, txc_irq, txd_o, txd_oe;
   logic                   rxd, rxd_tk, external_clock_pin, xck_tk, rx_v;
   logic [`UTR_DATA_W-1:0] rx_d;
   wire logic              txd_line;
   int                     bad_count, checks, cyc;

   // Released pin is pulled up
   assign txd_line = txd_oe ? txd_o : 1'b1;

   utr_datapath i_dut (
      .CLK(clk), .NRST(nrst), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .SYNC_MODE(sync),
      .DOUBLE_SPEED(dspd), .CHAR_SIZE(csz), .PARITY_EN(pe), .PARITY_ODD(po), .STOP_TWO(st2),
      .RATE_DIV(rdiv), .RATE_LOAD(rld), .NINTH_TX_BIT(ninth), .DATA_WR(wr_stb),
      .DATA_WDATA(wdat), .TXC_CLEAR(clr), .TXC_IRQ_ACK(ack), .BUF_EMPTY_IRQ_EN(be_ien),
      .TXC_IRQ_EN(txc_ien), .BUF_EMPTY_FLAG(be_flag), .TXC_FLAG(txc_flag),
      .BUF_EMPTY_IRQ(be_irq), .TXC_IRQ(txc_irq), .TXD_O(txd_o), .TXD_OE(txd_oe),
      .RXD_I(rxd), .RXD_TAKEN(rxd_tk), .XCK_I(external_clock_pin), .XCK_TAKEN(xck_tk), .RX_VALID(rx_v),
      .RX_READY(rdy), .RX_DATA(rx_d)
   );
   utr_peer i_peer (.external_clock_pin(external_clock_pin), .rxd(rxd), .txd(txd_line));

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run needs well under two thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic int ndat();
      return (csz == 3'h7) ? 9 : 5 + csz[1:0];
   endfunction : ndat

   function automatic int flen();
      return 2 + ndat() + pe + st2;
   endfunction : flen

   // Expected line image, stop and idle bits high
   function automatic logic [31:0] frame(input logic [8:0] d);
      logic [31:0] f;
      int          k;
      f = 32'hFFFF_FFFE;
      k = 1;
      for (int i = 0; i < ndat(); i++) begin
         f[k] = d[i];
         k++;
      end
      if (pe)
         f[k] = (^(d & ~(9'h1FF << ndat()))) ^ po;
      return f;
   endfunction : frame

   task automatic fmt(input logic [2:0] cs, input logic p, o, s, a);
      @(posedge clk);
      csz <= cs;
      pe <= p;
      po <= o;
      st2 <= s;
      txc_ien <= a;
      be_ien <= ~a;
      @(posedge clk);
   endtask : fmt

   task automatic wr(input logic [8:0] d);
      @(posedge clk);
      ninth <= d[8];
      @(posedge clk);
      wr_stb <= 1'b1;
      wdat <= d[7:0];
      @(posedge clk);
      wr_stb <= 1'b0;
      #1;
   endtask : wr

   // Either clear path, so the next send starts with a clear flag
   task automatic clear_txc(input logic a);
      @(posedge clk);
      clr <= ~a;
      ack <= a;
      @(posedge clk);
      clr <= 1'b0;
      ack <= 1'b0;
      #1;
      chk(txc_flag, 0);
   endtask : clear_txc

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      repeat (4) @(posedge clk);
      #1;
      chk(be_flag, 1);
      chk(txc_flag, 0);
      chk(be_irq, 1);
      chk(rx_v, 0);
      chk(txd_oe, 1);
      chk(txd_line, 1);
      chk(rxd_tk, 1);
      chk(xck_tk, 1);
      $display("reset test done");
   endtask : t_reset

   task automatic t_tx(input logic [2:0] cs, input logic p, o, s, input logic [8:0] d,
                       input logic a);
      fmt(cs, p, o, s, a);
      wr(d);
      chk(be_flag, 0);
      i_peer.run(flen(), 32'hFFFF_FFFF);
      chk(i_peer.cap, frame(d));
      @(posedge clk);
      #1;
      chk(txc_flag, 1);
      chk(txc_irq, a);
      chk(be_irq, !a);
      clear_txc(a);
      $display("tx test done");
   endtask : t_tx

   task automatic t_b2b;
      fmt(3'h3, 0, 0, 0, 0);
      wr(9'h03C);
      fork
         i_peer.run(2 * flen(), 32'hFFFF_FFFF);
         begin
            wait (be_flag === 1'b1);
            wr(9'h0C3);
            @(posedge clk);
            tx_en <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk(txd_oe, 1);
         end
      join
      chk(i_peer.cap, (frame(9'h0C3) << 10) | (frame(9'h03C) & 32'h0000_03FF));
      repeat (2) @(posedge clk);
      #1;
      chk(txd_oe, 0);
      chk(txc_flag, 1);
      clear_txc(1'b0);
      @(posedge clk);
      tx_en <= 1'b1;
      $display("back to back test done");
   endtask : t_b2b

   // Asynchronous double speed, divisor 1: one bit every 16 clocks, sampled mid-bit
   task automatic t_async;
      logic [31:0] got;
      got = 32'hFFFF_FFFF;
      fmt(3'h3, 0, 0, 0, 0);
      sync <= 1'b0;
      dspd <= 1'b1;
      rdiv <= 12'h001;
      rld <= 1'b1;
      @(posedge clk);
      rld <= 1'b0;
      wr(9'h05A);
      wait (txd_line === 1'b0);
      #321;
      for (int i = 0; i < 10; i++) begin
         got[i] = txd_line;
         #640;
      end
      chk(got, frame(9'h05A));
      chk(txc_flag, 1);
      clear_txc(1'b0);
      sync <= 1'b1;
      dspd <= 1'b0;
      rdiv <= 12'h000;
      $display("async test done");
   endtask : t_async

   // Receiver stalled: two words buffered, one held, the fourth lost
   task automatic t_rx;
      logic [8:0] v [4];
      v = '{9'h1FF, 9'h0A5, 9'h15A, 9'h033};
      fmt(3'h1, 1, 0, 1, 0);
      for (int i = 0; i < 4; i++)
         i_peer.run(flen(), frame(v[i]));
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         #1;
         chk(rx_v, 1);
         chk(rx_d, v[i] & 9'h03F);
         @(posedge clk);
         rdy <= 1'b1;
         @(posedge clk);
         rdy <= 1'b0;
      end
      repeat (4) @(posedge clk);
      #1;
      chk(rx_v, 0);
      $display("rx test done");
   endtask : t_rx

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst, wr_stb, ninth, clr, ack, txc_ien, rdy, pe, po, st2, dspd, rld} = '0;
      {tx_en, rx_en, be_ien, sync} = 4'hF;
      rdiv = 12'h000;
      csz = 3'h3;
      wdat = 8'h00;
      bad_count = 0;
      checks = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_tx(3'h3, 0, 0, 0, 9'h0A5, 0);
      t_tx(3'h0, 1, 0, 0, 9'h0F6, 1);
      t_tx(3'h7, 1, 1, 1, 9'h1C3, 0);
      t_tx(3'h2, 1, 1, 0, 9'h1FF, 1);
      t_tx(3'h1, 0, 0, 1, 9'h02A, 0);
      t_b2b();
      t_async();
      t_rx();
      final_report();
   end
endmodule : tb_top
